/* hw/bss_byte_pair.sv */
// Collects two bus bytes into one 16-bit word
`timescale 1ns/1ps
module bss_byte_pair
   import bss_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic clear,
   input wire logic load_lo,
   input wire logic load_hi,
   input wire logic [7:0] din,
   output logic [15:0] word
);
   logic [15:0] word_ff;
   logic [15:0] nxt_word;

   always_comb begin
      nxt_word = word_ff;
      if (clear) begin
         nxt_word = 16'h0000;
      end
      if (load_lo) begin
         nxt_word[7:0] = din;
      end
      if (load_hi) begin
         nxt_word[15:8] = din;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         word_ff <= 16'h0000;
      end else begin
         word_ff <= nxt_word;
      end
   end

   assign word = word_ff;
endmodule

/* hw/bss_sequencer.sv */
// Cycle sequencer for branches, interrupt entry and stack operations
`timescale 1ns/1ps
`include "bss_consts.svh"
module bss_sequencer
   import bss_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic start,
   input wire bss_req_s req,
   input wire logic [7:0] d_in,
   output logic ready,
   output logic done,
   output bss_bus_s bus,
   output bss_res_s result
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   bss_state_e state_ff, nxt_state;
   bss_req_s req_ff, nxt_req;
   logic [15:0] sp_ff, nxt_sp;
   logic [15:0] ea_ff, nxt_ea;
   bss_res_s res_ff, nxt_res;
   logic [15:0] word;
   logic accept;
   logic [15:0] push_word;
   logic [15:0] io_off;
   logic [15:0] tgt_pc;
   logic [7:0] tgt_bank;

   assign accept = start && (state_ff == ST_IDLE);
   assign ready = (state_ff == ST_IDLE);
   assign done = (state_ff == ST_NEXT);

   bss_byte_pair u_pair (
      .clock(clock),
      .rstn(rstn),
      .clear(accept),
      .load_lo((state_ff == ST_FETCH_LO) || (state_ff == ST_PTR_LO) ||
               (state_ff == ST_VEC_LO) || (state_ff == ST_PULL_LO)),
      .load_hi((state_ff == ST_FETCH_HI) || (state_ff == ST_PTR_HI) ||
               (state_ff == ST_VEC_HI) || (state_ff == ST_PULL_HI)),
      .din(d_in),
      .word(word)
   );

   // ----------------------------------------------------------------
   // Derived addresses and data
   // ----------------------------------------------------------------
   always_comb begin
      push_word = word;
      io_off = `BSS_LEN_ONE;
      tgt_bank = req_ff.program_bank;
      tgt_pc = req_ff.pc + `BSS_LEN_ONE;
      unique case (req_ff.op)
         OP_SHORT_BRANCH: begin
            // Not-taken branches fall through to the next opcode
            tgt_pc = req_ff.pc + `BSS_LEN_TWO;
            if (req_ff.taken) begin
               tgt_pc = req_ff.pc + `BSS_LEN_TWO +
                        {{8{word[7]}}, word[7:0]};
            end
         end
         OP_LONG_RELATIVE_BRANCH: begin
            io_off = `BSS_LEN_TWO;
            tgt_pc = req_ff.pc + `BSS_LEN_THREE + word;
         end
         OP_HW_INTERRUPT: begin
            io_off = 16'h0000;
            push_word = req_ff.pc;
            tgt_bank = `BSS_VECTOR_BANK;
            tgt_pc = word;
         end
         OP_PULL_REG: begin
         end
         OP_PUSH_REG: begin
            push_word = req_ff.reg_val;
         end
         OP_PUSH_EFF_ABSOLUTE: begin
            tgt_pc = req_ff.pc + `BSS_LEN_THREE;
         end
         OP_PUSH_EFF_INDIRECT: begin
            tgt_pc = req_ff.pc + `BSS_LEN_TWO;
         end
         OP_PUSH_EFF_RELATIVE: begin
            io_off = `BSS_LEN_TWO;
            // Carry from the low sum ripples into the high byte
            push_word = req_ff.pc + `BSS_LEN_THREE + word;
            tgt_pc = req_ff.pc + `BSS_LEN_THREE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Sequencing
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      nxt_req = req_ff;
      nxt_sp = sp_ff;
      nxt_ea = ea_ff;
      nxt_res = res_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (start) begin
               nxt_req = req;
               nxt_sp = req.sp;
               nxt_state = ST_OPCODE;
            end
         end
         ST_OPCODE: begin
            nxt_state = ST_IO_A;
            if (req_ff.op inside {OP_SHORT_BRANCH, OP_LONG_RELATIVE_BRANCH,
                  OP_PUSH_EFF_ABSOLUTE, OP_PUSH_EFF_INDIRECT,
                  OP_PUSH_EFF_RELATIVE}) begin
               nxt_state = ST_FETCH_LO;
            end
         end
         ST_FETCH_LO: begin
            nxt_state = ST_FETCH_HI;
            if (req_ff.op == OP_SHORT_BRANCH) begin
               nxt_state = req_ff.taken ? ST_IO_A : ST_NEXT;
            end else if (req_ff.op == OP_PUSH_EFF_INDIRECT) begin
               nxt_ea = req_ff.dp + {8'h00, d_in};
               nxt_state = req_ff.dl_nonzero ? ST_IO_A : ST_PTR_LO;
            end
         end
         ST_FETCH_HI: begin
            nxt_state = (req_ff.op == OP_PUSH_EFF_ABSOLUTE) ?
                        ST_PUSH_HI : ST_IO_A;
         end
         ST_IO_A: begin
            unique case (req_ff.op)
               OP_SHORT_BRANCH:
                  nxt_state = req_ff.extra_cycle ? ST_IO_B : ST_NEXT;
               OP_LONG_RELATIVE_BRANCH: nxt_state = ST_NEXT;
               OP_HW_INTERRUPT:
                  nxt_state = req_ff.native ? ST_PUSH_BANK :
                              ST_PUSH_HI;
               OP_PULL_REG: nxt_state = ST_IO_B;
               OP_PUSH_REG:
                  nxt_state = req_ff.wide ? ST_PUSH_HI : ST_PUSH_LO;
               OP_PUSH_EFF_ABSOLUTE: nxt_state = ST_PUSH_HI;
               OP_PUSH_EFF_INDIRECT: nxt_state = ST_PTR_LO;
               OP_PUSH_EFF_RELATIVE: nxt_state = ST_PUSH_HI;
            endcase
         end
         ST_IO_B: begin
            nxt_state = (req_ff.op == OP_PULL_REG) ? ST_PULL_LO : ST_NEXT;
         end
         ST_PUSH_BANK, ST_PUSH_HI: begin
            nxt_sp = sp_ff - `BSS_LEN_ONE;
            nxt_state = (state_ff == ST_PUSH_BANK) ? ST_PUSH_HI : ST_PUSH_LO;
         end
         ST_PUSH_LO: begin
            nxt_sp = sp_ff - `BSS_LEN_ONE;
            nxt_state = (req_ff.op == OP_HW_INTERRUPT) ?
                        ST_PUSH_STATUS : ST_NEXT;
         end
         ST_PUSH_STATUS: begin
            nxt_sp = sp_ff - `BSS_LEN_ONE;
            nxt_state = ST_VEC_LO;
         end
         ST_VEC_LO: nxt_state = ST_VEC_HI;
         ST_VEC_HI: nxt_state = ST_NEXT;
         ST_PULL_LO: begin
            nxt_sp = sp_ff + `BSS_LEN_ONE;
            nxt_state = req_ff.wide ? ST_PULL_HI : ST_NEXT;
         end
         ST_PULL_HI: begin
            nxt_sp = sp_ff + `BSS_LEN_ONE;
            nxt_state = ST_NEXT;
         end
         ST_PTR_LO: nxt_state = ST_PTR_HI;
         ST_PTR_HI: nxt_state = ST_PUSH_HI;
         ST_NEXT: begin
            nxt_res.program_bank = tgt_bank;
            nxt_res.pc = tgt_pc;
            nxt_res.sp = sp_ff;
            nxt_res.pulled = word;
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
         req_ff <= '0;
         sp_ff <= 16'h0000;
         ea_ff <= 16'h0000;
         res_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         req_ff <= nxt_req;
         sp_ff <= nxt_sp;
         ea_ff <= nxt_ea;
         res_ff <= nxt_res;
      end
   end

   assign result = res_ff;

   // ----------------------------------------------------------------
   // Bus cycle decode
   // ----------------------------------------------------------------
   always_comb begin
      bus.bank = req_ff.program_bank;
      bus.addr = req_ff.pc + io_off;
      bus.dout = 8'h00;
      bus.read_write_n = 1'b1;
      bus.valid_data_addr = 1'b0;
      bus.valid_prog_addr = 1'b0;
      bus.vector_pull_n = `BSS_VPULL_IDLE;
      // Lock never asserts: none of these sequences is read-modify-write
      bus.memory_lock_n = `BSS_LOCK_IDLE;
      unique case (state_ff)
         ST_IDLE: begin
            bus.bank = 8'h00;
            bus.addr = 16'h0000;
         end
         ST_OPCODE: begin
            bus.addr = req_ff.pc;
            bus.valid_data_addr = 1'b1;
            bus.valid_prog_addr = 1'b1;
         end
         ST_FETCH_LO, ST_FETCH_HI: begin
            bus.addr = req_ff.pc + ((state_ff == ST_FETCH_LO) ?
                       `BSS_LEN_ONE : `BSS_LEN_TWO);
            bus.valid_prog_addr = 1'b1;
         end
         ST_IO_A, ST_IO_B: begin
         end
         ST_PUSH_BANK, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_STATUS: begin
            bus.bank = `BSS_STACK_BANK;
            bus.addr = sp_ff;
            bus.read_write_n = 1'b0;
            bus.valid_data_addr = 1'b1;
            unique case (state_ff)
               ST_PUSH_BANK: bus.dout = req_ff.program_bank;
               ST_PUSH_HI: bus.dout = push_word[15:8];
               ST_PUSH_LO: bus.dout = push_word[7:0];
               default: bus.dout = req_ff.status;
            endcase
         end
         ST_VEC_LO, ST_VEC_HI: begin
            bus.bank = `BSS_VECTOR_BANK;
            bus.addr = req_ff.vector + ((state_ff == ST_VEC_LO) ?
                       16'h0000 : `BSS_LEN_ONE);
            bus.valid_data_addr = 1'b1;
            bus.vector_pull_n = 1'b0;
         end
         ST_PULL_LO, ST_PULL_HI: begin
            bus.bank = `BSS_STACK_BANK;
            bus.addr = sp_ff + `BSS_LEN_ONE;
            bus.valid_data_addr = 1'b1;
         end
         ST_PTR_LO, ST_PTR_HI: begin
            bus.bank = `BSS_DIRECT_BANK;
            bus.addr = ea_ff + ((state_ff == ST_PTR_LO) ?
                       16'h0000 : `BSS_LEN_ONE);
            bus.valid_data_addr = 1'b1;
         end
         ST_NEXT: begin
            bus.bank = tgt_bank;
            bus.addr = tgt_pc;
            bus.valid_data_addr = 1'b1;
            bus.valid_prog_addr = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   lock_never_low_a: assert property (
      @(posedge clock) disable iff (!rstn) bus.memory_lock_n == 1'b1)
      else $error("memory lock asserted");

   next_fetch_qual_a: assert property (
      @(posedge clock) disable iff (!rstn)
      done |-> bus.valid_data_addr && bus.valid_prog_addr &&
               bus.read_write_n)
      else $error("opcode fetch qualifiers wrong");

   short_not_taken_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_SHORT_BRANCH && !req.taken |->
      ##3 (done && bus.addr == req_ff.pc + 16'h0002))
      else $error("untaken branch length or target wrong");

   offset_fetch_a: assert property (
      @(posedge clock) disable iff (!rstn)
      state_ff == ST_FETCH_LO |-> bus.valid_prog_addr &&
      !bus.valid_data_addr && bus.read_write_n &&
      bus.addr == req_ff.pc + 16'h0001)
      else $error("offset fetch cycle wrong");

   long_branch_len_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_LONG_RELATIVE_BRANCH |->
      ##4 (!done && !bus.valid_prog_addr) ##1 done)
      else $error("long branch length wrong");

   int_entry_len_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_HW_INTERRUPT && req.native |->
      ##2 (!bus.valid_data_addr && !bus.valid_prog_addr) ##7 done)
      else $error("interrupt entry length wrong");

   int_entry_emu_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_HW_INTERRUPT && !req.native |->
      ##2 (!bus.valid_data_addr && !bus.valid_prog_addr) ##6 done)
      else $error("emulation interrupt length wrong");

   int_bank_push_a: assert property (
      @(posedge clock) disable iff (!rstn)
      state_ff == ST_PUSH_BANK |-> req_ff.native &&
      bus.addr == req_ff.sp && bus.dout == req_ff.program_bank)
      else $error("bank push wrong");

   stack_write_a: assert property (
      @(posedge clock) disable iff (!rstn)
      !bus.read_write_n && $past(!bus.read_write_n) |->
      bus.bank == 8'h00 && bus.addr == $past(bus.addr) - 16'h0001)
      else $error("stack writes not descending in bank zero");

   vector_pull_a: assert property (
      @(posedge clock) disable iff (!rstn)
      state_ff == ST_VEC_LO |-> !bus.vector_pull_n && bus.read_write_n
      ##1 !bus.vector_pull_n && bus.addr == $past(bus.addr) + 16'h0001
      ##1 done && bus.vector_pull_n)
      else $error("vector pull sequence wrong");

   pull_wide_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_PULL_REG && req.wide |->
      ##4 (bus.addr == req_ff.sp + 16'h0001) ##1
      (bus.addr == req_ff.sp + 16'h0002) ##1 done)
      else $error("pull sequence wrong");

   push_abs_len_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_PUSH_EFF_ABSOLUTE |->
      ##4 (!bus.read_write_n && bus.addr == req_ff.sp) ##2 done)
      else $error("absolute push sequence wrong");

   ptr_read_a: assert property (
      @(posedge clock) disable iff (!rstn)
      state_ff == ST_PTR_HI |-> bus.addr == $past(bus.addr) + 16'h0001)
      else $error("pointer reads not consecutive");

   push_rel_len_a: assert property (
      @(posedge clock) disable iff (!rstn)
      accept && req.op == OP_PUSH_EFF_RELATIVE |-> ##7 done)
      else $error("relative push length wrong");

   push_reg_a: assert property (
      @(posedge clock) disable iff (!rstn)
      state_ff == ST_PUSH_HI && req_ff.op == OP_PUSH_REG |->
      ##1 (state_ff == ST_PUSH_LO && bus.dout == req_ff.reg_val[7:0]))
      else $error("register push order wrong");
endmodule

/* shared/bss_consts.svh */
// Constants for the branch, stack and bus cycle sequencer
`ifndef BSS_CONSTS_SVH
`define BSS_CONSTS_SVH

`define BSS_STACK_BANK 8'h00
`define BSS_VECTOR_BANK 8'h00
`define BSS_DIRECT_BANK 8'h00
`define BSS_LEN_ONE 16'h0001
`define BSS_LEN_TWO 16'h0002
`define BSS_LEN_THREE 16'h0003
`define BSS_LOCK_IDLE 1'b1
`define BSS_VPULL_IDLE 1'b1

`endif

/* shared/bss_pkg.sv */
// Types shared by the branch, stack and bus cycle sequencer
package bss_pkg;

   typedef enum logic [2:0] {
      OP_SHORT_BRANCH,
      OP_LONG_RELATIVE_BRANCH,
      OP_HW_INTERRUPT,
      OP_PULL_REG,
      OP_PUSH_REG,
      OP_PUSH_EFF_ABSOLUTE,
      OP_PUSH_EFF_INDIRECT,
      OP_PUSH_EFF_RELATIVE
   } bss_op_e;

   typedef enum logic [4:0] {
      ST_IDLE, ST_OPCODE, ST_FETCH_LO, ST_FETCH_HI, ST_IO_A, ST_IO_B,
      ST_PUSH_BANK, ST_PUSH_HI, ST_PUSH_LO, ST_PUSH_STATUS,
      ST_VEC_LO, ST_VEC_HI, ST_PULL_LO, ST_PULL_HI,
      ST_PTR_LO, ST_PTR_HI, ST_NEXT
   } bss_state_e;

   typedef struct packed {
      bss_op_e op;
      logic taken;
      logic extra_cycle;
      logic native;
      logic wide;
      logic dl_nonzero;
      logic [7:0] program_bank;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] dp;
      logic [15:0] reg_val;
      logic [7:0] status;
      logic [15:0] vector;
   } bss_req_s;

   typedef struct packed {
      logic [7:0] bank;
      logic [15:0] addr;
      logic [7:0] dout;
      logic read_write_n;
      logic valid_data_addr;
      logic valid_prog_addr;
      logic vector_pull_n;
      logic memory_lock_n;
   } bss_bus_s;

   typedef struct packed {
      logic [7:0] program_bank;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] pulled;
   } bss_res_s;

endpackage

/* tb/branch_stack_bus_cycle_sequencer_bench.sv */
// Self-checking bench for the branch, stack and bus cycle sequencer
`timescale 1ns/1ps
module branch_stack_bus_cycle_sequencer_bench
   import bss_pkg::*;
;
   typedef struct {
      bss_req_s r;
      logic [15:0] opnd;
      int len;
   } bss_row_s;

   logic clock;
   logic rstn;
   logic start;
   bss_req_s req;
   logic [7:0] d_in;
   logic ready;
   logic done;
   bss_bus_s bus;
   bss_res_s result;
   bss_bus_s eq[$];
   bss_res_s er;
   logic [15:0] sp_e;
   bss_row_s rows[14];
   int errors;
   int comparisons;

   bss_sequencer dut (.clock(clock), .rstn(rstn), .start(start),
      .req(req), .d_in(d_in), .ready(ready), .done(done), .bus(bus),
      .result(result));
   bss_mem_model memory (.clock(clock), .rstn(rstn), .bus(bus),
      .d_in(d_in));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // ----------------------------------------
   // Compare tasks
   // ----------------------------------------
   task automatic fail(input string msg);
      errors++;
      $display("Error at %0t: %s", $time, msg);
   endtask

   // Data lines are only meaningful on write cycles
   task automatic chk_bus(input bss_bus_s got, input bss_bus_s exp);
      comparisons++;
      if (exp.read_write_n) exp.dout = got.dout;
      if (got !== exp) fail($sformatf("bus %h want %h", got, exp));
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string s);
      comparisons++;
      if (got !== exp) fail(s);
   endtask

   task automatic chk_res(input bss_res_s got, input bss_res_s exp);
      comparisons++;
      if (got !== exp) fail($sformatf("result %h want %h", got, exp));
   endtask

   task automatic end_sim();
      if (errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Expected cycle list
   // ----------------------------------------
   task automatic cyc(input logic [7:0] b, input logic [15:0] a,
         input logic [7:0] d, input logic [2:0] rqv, input logic vp);
      eq.push_back(bss_bus_s'{b, a, d, rqv[2], rqv[1], rqv[0], vp, 1'b1});
   endtask

   task automatic psh(input logic [7:0] d);
      cyc(8'h00, sp_e, d, 3'b010, 1'b1);
      sp_e = sp_e - 16'h0001;
   endtask

   task automatic build(input bss_row_s w);
      bss_req_s r;
      logic [15:0] t;
      logic [7:0] pb;
      r = w.r;
      pb = r.program_bank;
      sp_e = r.sp;
      eq.delete();
      er = '{pb, r.pc + 16'h0001, r.sp, 16'h0000};
      cyc(pb, r.pc, 8'h00, 3'b111, 1'b1);
      case (r.op)
         OP_SHORT_BRANCH: begin
            cyc(pb, r.pc + 16'h0001, 8'h00, 3'b101, 1'b1);
            if (r.taken) cyc(pb, r.pc + 16'h0001, 8'h00, 3'b100, 1'b1);
            if (r.taken && r.extra_cycle)
               cyc(pb, r.pc + 16'h0001, 8'h00, 3'b100, 1'b1);
            t = r.taken ? {{8{w.opnd[7]}}, w.opnd[7:0]} : 16'h0000;
            er.pc = r.pc + 16'h0002 + t;
         end
         OP_LONG_RELATIVE_BRANCH, OP_PUSH_EFF_ABSOLUTE,
         OP_PUSH_EFF_RELATIVE: begin
            cyc(pb, r.pc + 16'h0001, 8'h00, 3'b101, 1'b1);
            cyc(pb, r.pc + 16'h0002, 8'h00, 3'b101, 1'b1);
            er.pc = r.pc + 16'h0003;
            t = (r.op == OP_PUSH_EFF_ABSOLUTE) ? w.opnd : er.pc + w.opnd;
            if (r.op != OP_PUSH_EFF_ABSOLUTE)
               cyc(pb, r.pc + 16'h0002, 8'h00, 3'b100, 1'b1);
            if (r.op == OP_LONG_RELATIVE_BRANCH) begin
               er.pc = t;
            end else begin
               psh(t[15:8]);
               psh(t[7:0]);
            end
         end
         OP_HW_INTERRUPT: begin
            cyc(pb, r.pc, 8'h00, 3'b100, 1'b1);
            if (r.native) psh(pb);
            psh(r.pc[15:8]);
            psh(r.pc[7:0]);
            psh(r.status);
            cyc(8'h00, r.vector, 8'h00, 3'b110, 1'b0);
            cyc(8'h00, r.vector + 16'h0001, 8'h00, 3'b110, 1'b0);
            er.program_bank = 8'h00;
            er.pc = {memory.peek({8'h00, r.vector + 16'h0001}),
               memory.peek({8'h00, r.vector})};
         end
         OP_PULL_REG: begin
            repeat (2) cyc(pb, r.pc + 16'h0001, 8'h00, 3'b100, 1'b1);
            for (int i = 1; i <= (r.wide ? 2 : 1); i++) begin
               sp_e = sp_e + 16'h0001;
               cyc(8'h00, sp_e, 8'h00, 3'b110, 1'b1);
               er.pulled = {memory.peek({8'h00, sp_e}), er.pulled[15:8]};
            end
            if (!r.wide) er.pulled = {8'h00, er.pulled[15:8]};
         end
         OP_PUSH_REG: begin
            cyc(pb, r.pc + 16'h0001, 8'h00, 3'b100, 1'b1);
            if (r.wide) psh(r.reg_val[15:8]);
            psh(r.reg_val[7:0]);
         end
         default: begin
            cyc(pb, r.pc + 16'h0001, 8'h00, 3'b101, 1'b1);
            if (r.dl_nonzero) cyc(pb, r.pc + 16'h0001, 8'h00, 3'b100, 1'b1);
            t = r.dp + {8'h00, w.opnd[7:0]};
            cyc(8'h00, t, 8'h00, 3'b110, 1'b1);
            cyc(8'h00, t + 16'h0001, 8'h00, 3'b110, 1'b1);
            psh(memory.peek({8'h00, t + 16'h0001}));
            psh(memory.peek({8'h00, t}));
            er.pc = r.pc + 16'h0002;
         end
      endcase
      er.sp = sp_e;
      cyc(er.program_bank, er.pc, 8'h00, 3'b111, 1'b1);
   endtask

   // ----------------------------------------
   // One operation; poke raises start while busy
   // ----------------------------------------
   task automatic run_op(input bss_row_s w, input int poke);
      memory.load({w.r.program_bank, w.r.pc + 16'h0001}, w.opnd[7:0]);
      memory.load({w.r.program_bank, w.r.pc + 16'h0002}, w.opnd[15:8]);
      build(w);
      @(posedge clock);
      start <= 1'b1;
      req <= w.r;
      for (int k = 1; k <= w.len; k++) begin
         @(posedge clock);
         start <= (k == poke);
         @(negedge clock);
         chk_bus(bus, eq[k - 1]);
         chk_bit(done, k == w.len, "done timing");
      end
      @(posedge clock);
      start <= 1'b0;
      @(negedge clock);
      if (w.r.op != OP_PULL_REG) er.pulled = result.pulled;
      chk_res(result, er);
      chk_bit(ready, 1'b1, "not ready");
      chk_bit(bus.valid_data_addr | bus.valid_prog_addr, 1'b0, "busy");
   endtask

   function automatic bss_row_s mk(input bss_op_e op, input logic [4:0] f,
         input logic [15:0] pc, input logic [15:0] sp,
         input logic [15:0] opnd, input int len);
      mk.r = '{op, f[4], f[3], f[2], f[1], f[0], 8'h12, pc, sp,
         16'h0300, 16'hA55A, 8'hC3, 16'hFFEA};
      mk.opnd = opnd;
      mk.len = len;
   endfunction

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      start = 1'b0;
      req = '0;
      errors = 0;
      comparisons = 0;
      rows[0] = mk(OP_SHORT_BRANCH, 5'h00, 16'h1000, 16'h01FF, 16'h007F, 3);
      rows[1] = mk(OP_SHORT_BRANCH, 5'h10, 16'h2040, 16'h01FF, 16'h0080, 4);
      rows[2] = mk(OP_SHORT_BRANCH, 5'h18, 16'hFFFE, 16'h01FF, 16'h00FE, 5);
      rows[3] = mk(OP_LONG_RELATIVE_BRANCH, 5'h00, 16'h3000, 16'h01FF,
         16'h8001, 5);
      rows[4] = mk(OP_HW_INTERRUPT, 5'h04, 16'h4321, 16'h01FF, 16'h0, 9);
      rows[5] = mk(OP_HW_INTERRUPT, 5'h00, 16'h4321, 16'h01FF, 16'h0, 8);
      rows[6] = mk(OP_PULL_REG, 5'h02, 16'h5000, 16'hFFFE, 16'h0, 6);
      rows[7] = mk(OP_PULL_REG, 5'h00, 16'h5000, 16'h01F0, 16'h0, 5);
      rows[8] = mk(OP_PUSH_REG, 5'h02, 16'h6000, 16'h0000, 16'h0, 5);
      rows[9] = mk(OP_PUSH_REG, 5'h00, 16'h6000, 16'h01FF, 16'h0, 4);
      rows[10] = mk(OP_PUSH_EFF_ABSOLUTE, 5'h00, 16'h7000, 16'h01FF,
         16'hBEEF, 6);
      rows[11] = mk(OP_PUSH_EFF_INDIRECT, 5'h00, 16'h8000, 16'h01FF,
         16'h0040, 7);
      rows[12] = mk(OP_PUSH_EFF_INDIRECT, 5'h01, 16'h8000, 16'h01FF,
         16'h00FF, 8);
      rows[13] = mk(OP_PUSH_EFF_RELATIVE, 5'h00, 16'h12F0, 16'h01FF,
         16'h0020, 7);
      repeat (3) @(posedge clock);
      rstn <= 1'b1;
      @(negedge clock);
      chk_res(result, '0);
      chk_bus(bus, bss_bus_s'{8'h00, 16'h0000, 8'h00, 1'b1, 1'b0, 1'b0,
         1'b1, 1'b1});
      foreach (rows[i]) run_op(rows[i], 0);
      run_op(rows[4], 3);
      // Reset in mid-operation must drop the bus at once
      @(posedge clock);
      start <= 1'b1;
      req <= rows[13].r;
      @(posedge clock);
      start <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b0;
      @(negedge clock);
      chk_bit(done, 1'b0, "done in reset");
      chk_bit(ready, 1'b1, "ready in reset");
      chk_res(result, '0);
      chk_bus(bus, bss_bus_s'{8'h00, 16'h0000, 8'h00, 1'b1, 1'b0, 1'b0,
         1'b1, 1'b1});
      @(posedge clock);
      rstn <= 1'b1;
      run_op(rows[1], 0);
      end_sim();
   end

   // Whole run is about 135 cycles
   initial begin
      repeat (3000) @(posedge clock);
      fail("timeout");
      end_sim();
   end
endmodule

/* tb/bss_mem_model.sv */
// Memory and decode model that answers the sequencer's read cycles
`timescale 1ns/1ps
module bss_mem_model
   import bss_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire bss_bus_s bus,
   output logic [7:0] d_in
);
   logic [7:0] mem [logic [23:0]];
   logic [7:0] last_ff;
   logic rd_cyc;

   // ----------------------------------------
   // Contents
   // ----------------------------------------
   // Unloaded bytes follow a pattern of their address: its three bytes XORed with 3C
   function automatic logic [7:0] peek(input logic [23:0] a);
      if (mem.exists(a)) begin
         return mem[a];
      end
      return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3C;
   endfunction

   task automatic load(input logic [23:0] a, input logic [7:0] v);
      mem[a] = v;
   endtask

   // ----------------------------------------
   // Data lines
   // ----------------------------------------
   assign rd_cyc = bus.read_write_n &&
      (bus.valid_data_addr || bus.valid_prog_addr);

   // Off a read the lines flip every cycle, never a stale copy
   always_comb begin
      d_in = rd_cyc ? peek({bus.bank, bus.addr}) : ~last_ff;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         last_ff <= 8'h00;
      end else begin
         last_ff <= d_in;
      end
   end
endmodule
